// ===== design/tpd_cmd_top.sv
// command interpreter for position query and diagnostic-results fetch
// --------------------------------------------------------------------
// Notes on behaviour
// R1: position query reports position, never moves tape
// R2: legacy-format tape rejects query as illegal request
// R3: no cartridge: not ready, 3Ah/00h
// R4: block type 0 reports logical block number
// R5: position query returns its data block
// R6: byte 0 bit 7 flags partition start
// R7: byte 0 bit 6 flags near partition end
// R8: byte 0 bit 2 flags position unknown
// R9: partition field 1 first, 0 second/none
// R10: bytes 4-7 give next block address
// R11: query after immediate rewind may show old position
// R12: last block and buffer counts read zero
// R13: opcode 1Ch fetches diagnostics, 16-bit allocation
// R14: CDB byte 5 bit 7 picks trace
// R15: zero allocation sends nothing, no error
// R16: data-in ends at smaller of allocation, available
// R17: initiator allocates page length plus four
// R18: initiator allocates 500h for the trace
// R19: initiator fetches right after self-test, reserved
// R20: page code 90h, 91h or 94h
// R21: self-test parameter 00h pass, else symptom code
// R22: trace dump holds 1280 bytes
// R23: last self-test outcome kept until replaced
// R24: multi-byte position fields are big-endian
// --------------------------------------------------------------------
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module tpd_cmd_top (
    input wire logic clk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // drive state
    input wire logic cartridgePresent,
    input wire logic legacyFormat,
    input wire logic positionKnown,
    input wire logic atPartitionStart,
    input wire logic nearPartitionEnd,
    input wire logic dualPartition,
    input wire logic inFirstPartition,
    input wire logic [31:0] nextBlockAddr,
    // self-test outcome
    input wire logic selfTestDone,
    input wire logic [7:0] selfTestPage,
    input wire logic [7:0] selfTestCode,
    input wire logic [15:0] dumpLength,
    // trace / dump memory read port (combinational read)
    output logic [15:0] memAddr,
    output logic memTraceSel,
    input wire logic [7:0] memData,
    // data-in phase
    output logic dataInValid,
    output logic [7:0] dataInByte,
    input wire logic dataInReady
);
    import tpd_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    tpd_stream_if strm ();

    tpd_state_e stateFf; // sequencer state
    logic ackFf; // bus answer cycle
    logic [47:0] cdbFf; // command block, byte 0 in bits 7:0
    logic doneFf; // command finished, sticky
    logic [7:0] statusFf; // status byte of last command
    logic [3:0] senseKeyFf; // sense key of last command
    logic [7:0] ascFf; // additional sense code
    logic [7:0] ascqFf; // additional sense qualifier
    logic startFf; // sender launch pulse
    logic [15:0] countFf; // cut transfer length
    logic pageValidFf; // a self-test outcome is held
    logic [7:0] pageCodeFf; // held page code
    logic [7:0] pageParamFf; // held pass/fail code
    logic [15:0] pageLenFf; // held page length field

    logic busTake; // bus access completes this edge
    logic goWrite; // software launches the command
    logic [7:0] opcode; // command byte 0
    logic traceSel; // trace selected in the fetch
    logic [15:0] allocLen; // fetch allocation length
    logic [15:0] availLen; // bytes the fetch could return
    logic [7:0] posByte; // position response byte at index
    logic [7:0] pageByte; // diagnostic page byte at index
    logic [15:0] diagIdx; // parameter index past the page header

    // ----------------------------------------------------------------
    // avalon-mm slave
    // ----------------------------------------------------------------
    // every access waits one cycle, then completes
    assign waitrequest = (read || write) && !ackFf;
    assign busTake = (read || write) && ackFf;
    assign goWrite = write && ackFf && (address == REG_CTRL) && writedata[0];

    // answer cycle toggles in behind each request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ackFf <= 1'b0;
        end else begin
            ackFf <= (read || write) && !ackFf;
        end
    end

    // read data loaded in the wait cycle, stands at the taking edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= 32'h0000_0000;
        end else if ((read && !ackFf)) begin
            unique case (address)
                REG_CDB_LO: readdata <= cdbFf[31:0];
                REG_CDB_HI: readdata <= {16'h0000, cdbFf[47:32]};
                REG_STATUS: readdata <= {ascqFf, ascFf, statusFf, 2'b00,
                                         senseKeyFf, (stateFf != TPD_IDLE), doneFf};
                default: readdata <= 32'h0000_0000; // control and unmapped read zero
            endcase
        end
    end

    // command block registers, writable only while idle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cdbFf <= 48'h0;
        end else if (write && ackFf && stateFf == TPD_IDLE) begin
            if (address == REG_CDB_LO) begin
                cdbFf[31:0] <= writedata;
            end else if (address == REG_CDB_HI) begin
                cdbFf[47:32] <= writedata[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    assign opcode = cdbFf[7:0];
    assign traceSel = cdbFf[40 + TRACE_DUMP_SELECT_BIT]; // (see R14)
    assign allocLen = {cdbFf[31:24], cdbFf[39:32]}; // bytes 3 and 4, high first (see R13)

    // available bytes: full trace, or held page plus its header
    always_comb begin
        if (traceSel) begin
            availLen = TRACE_LEN; // (see R22)
        end else if (pageValidFf) begin
            availLen = pageLenFf + DIAG_HDR_LEN;
        end else begin
            availLen = 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // self-test outcome store
    // ----------------------------------------------------------------
    // kept across fetches until the next self-test replaces it (see R23)
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pageValidFf <= 1'b0;
            pageCodeFf <= PAGE_POWER_ON;
            pageParamFf <= CODE_PASS;
            pageLenFf <= 16'h0000;
        end else if (selfTestDone) begin
            pageValidFf <= 1'b1;
            pageCodeFf <= selfTestPage; // (see R20)
            pageParamFf <= selfTestCode; // 00h pass, else symptom (see R21)
            pageLenFf <= (selfTestPage == PAGE_MEM_DUMP) ? dumpLength : SELFTEST_PARAM_LEN;
        end
    end

    // ----------------------------------------------------------------
    // response byte sources
    // ----------------------------------------------------------------
    // block number only, no motion request leaves this block (see R1)
    // address reported as the drive gives it, even mid-rewind (see R11)
    tpd_pos_fmt u_pos_fmt (
        .index(strm.index),
        .atStart(atPartitionStart),
        .nearEnd(nearPartitionEnd),
        .posUnknown(!positionKnown),
        .dualPartition(dualPartition),
        .inFirstPartition(inFirstPartition),
        .nextBlockAddr(nextBlockAddr),
        .respByte(posByte)
    );

    assign diagIdx = strm.index - DIAG_HDR_LEN;
    assign memTraceSel = traceSel;
    assign memAddr = traceSel ? strm.index : diagIdx;

    // diagnostic page: code, reserved, length, then parameters
    always_comb begin
        unique case (strm.index)
            16'h0000: pageByte = pageCodeFf;
            16'h0001: pageByte = 8'h00;
            16'h0002: pageByte = pageLenFf[15:8];
            16'h0003: pageByte = pageLenFf[7:0];
            default: pageByte = (pageCodeFf == PAGE_MEM_DUMP) ? memData : pageParamFf;
        endcase
    end

    // pick the source for the running command
    always_comb begin
        if (opcode == OP_POS_QUERY) begin
            strm.srcByte = posByte;
        end else if (traceSel) begin
            strm.srcByte = memData;
        end else begin
            strm.srcByte = pageByte;
        end
    end

    assign strm.start = startFf;
    assign strm.count = countFf;

    tpd_byte_sender u_sender (
        .clk(clk),
        .reset_n(reset_n),
        .strm(strm),
        .dataInValid(dataInValid),
        .dataInByte(dataInByte),
        .dataInReady(dataInReady)
    );

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stateFf <= TPD_IDLE;
        end else begin
            unique case (stateFf)
                TPD_IDLE: if (goWrite) stateFf <= TPD_DECODE;
                TPD_DECODE: stateFf <= startFf ? TPD_SEND : TPD_FINISH;
                TPD_SEND: if (!strm.busy) stateFf <= TPD_FINISH;
                TPD_FINISH: stateFf <= TPD_IDLE;
            endcase
        end
    end

    // launch pulse and cut length, prepared on entry to decode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            startFf <= 1'b0;
            countFf <= 16'h0000;
        end else if (goWrite && stateFf == TPD_IDLE) begin
            if (opcode == OP_POS_QUERY) begin
                // errors are checked in decode; start only when clean
                startFf <= cartridgePresent && !legacyFormat &&
                           !cdbFf[8 + BLOCK_NUMBER_TYPE_BIT]; // (see R4)
                countFf <= POS_RESP_LEN; // (see R5)
            end else if (opcode == OP_DIAG_FETCH) begin
                // smaller of allocation and available (see R16)
                countFf <= (allocLen < availLen) ? allocLen : availLen;
                startFf <= (allocLen != 16'h0000) && (availLen != 16'h0000); // (see R15)
            end else begin
                startFf <= 1'b0;
                countFf <= 16'h0000;
            end
        end else begin
            startFf <= 1'b0;
        end
    end

    // status and sense, fixed in decode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            statusFf <= ST_GOOD;
            senseKeyFf <= SK_NONE;
            ascFf <= ASC_NONE;
            ascqFf <= ASCQ_NONE;
        end else if (stateFf == TPD_DECODE) begin
            statusFf <= ST_GOOD;
            senseKeyFf <= SK_NONE;
            ascFf <= ASC_NONE;
            ascqFf <= ASCQ_NONE;
            if (opcode == OP_POS_QUERY) begin
                if (!cartridgePresent) begin
                    statusFf <= ST_CHECK; // (see R3)
                    senseKeyFf <= SK_NOT_READY;
                    ascFf <= ASC_NO_MEDIUM;
                end else if (legacyFormat) begin
                    statusFf <= ST_CHECK; // (see R2)
                    senseKeyFf <= SK_ILLEGAL;
                    ascFf <= ASC_INCOMPAT;
                end else if (cdbFf[8 + BLOCK_NUMBER_TYPE_BIT]) begin
                    statusFf <= ST_CHECK; // vendor block number absent
                    senseKeyFf <= SK_ILLEGAL;
                    ascFf <= ASC_BAD_FIELD;
                end
            end else if (opcode != OP_DIAG_FETCH) begin
                statusFf <= ST_CHECK; // unknown operation code
                senseKeyFf <= SK_ILLEGAL;
                ascFf <= ASC_BAD_OPCODE;
            end
        end
    end

    // done flag: finish sets it, a new launch clears it; set wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            doneFf <= 1'b0;
        end else if (stateFf == TPD_FINISH) begin
            doneFf <= 1'b1;
        end else if (goWrite && stateFf == TPD_IDLE) begin
            doneFf <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_no_medium_sense: assert property (@(posedge clk) disable iff (!reset_n) // see R3
        (stateFf == TPD_DECODE && opcode == OP_POS_QUERY && !cartridgePresent) |=>
        (statusFf == ST_CHECK && senseKeyFf == SK_NOT_READY && ascFf == ASC_NO_MEDIUM
         && ascqFf == ASCQ_NONE))
        else $error("missing cartridge not reported as not ready");
    a_legacy_reject: assert property (@(posedge clk) disable iff (!reset_n) // see R2
        (stateFf == TPD_DECODE && opcode == OP_POS_QUERY && cartridgePresent
         && legacyFormat) |=> (statusFf == ST_CHECK && senseKeyFf == SK_ILLEGAL))
        else $error("legacy tape not rejected");
    a_error_no_data: assert property (@(posedge clk) disable iff (!reset_n) // see R2
        (stateFf == TPD_DECODE && !startFf) |=> !dataInValid [*2])
        else $error("data sent on a failed command");
    a_zero_alloc_good: assert property (@(posedge clk) disable iff (!reset_n) // see R15
        (stateFf == TPD_DECODE && opcode == OP_DIAG_FETCH && allocLen == 16'h0000)
        |-> !startFf ##1 (statusFf == ST_GOOD))
        else $error("zero allocation mishandled");
    a_cut_length: assert property (@(posedge clk) disable iff (!reset_n) // see R16
        (stateFf == TPD_DECODE && opcode == OP_DIAG_FETCH) |->
        (countFf <= allocLen && countFf <= availLen))
        else $error("transfer longer than allocation or data");
    a_unknown_flag: assert property (@(posedge clk) disable iff (!reset_n) // see R8
        (stateFf == TPD_SEND && opcode == OP_POS_QUERY && strm.index == 16'h0000)
        |-> (posByte[POSITION_UNKNOWN_BIT] == !positionKnown))
        else $error("position unknown flag wrong");
    a_zero_fields: assert property (@(posedge clk) disable iff (!reset_n) // see R12
        (strm.index >= 16'h0008 && strm.index < POS_RESP_LEN) |-> (posByte == 8'h00))
        else $error("unsupported position field not zero");
    a_partition_field: assert property (@(posedge clk) disable iff (!reset_n) // see R9
        (strm.index == 16'h0001 && !dualPartition) |-> (posByte == 8'h00))
        else $error("partition number nonzero on unpartitioned tape");
    a_done_after_send: assert property (@(posedge clk) disable iff (!reset_n) // see R16
        (stateFf == TPD_SEND && !strm.busy) |=> (stateFf == TPD_FINISH) ##1 doneFf)
        else $error("command did not complete after data phase");
endmodule

// ===== shared/tpd_pkg.sv
// constants for the tape position and diagnostic command block
package tpd_pkg;
    // ----------------------------------------------------------------
    // operation codes and status answers
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_POS_QUERY = 8'h34;
    localparam logic [7:0] OP_DIAG_FETCH = 8'h1c;
    localparam logic [7:0] ST_GOOD = 8'h00;
    localparam logic [7:0] ST_CHECK = 8'h02;
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_NOT_READY = 4'h2;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_NO_MEDIUM = 8'h3a;
    localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
    localparam logic [7:0] ASC_INCOMPAT = 8'h30;
    localparam logic [7:0] ASCQ_NONE = 8'h00;
    // ----------------------------------------------------------------
    // command block field positions
    // ----------------------------------------------------------------
    localparam int BLOCK_NUMBER_TYPE_BIT = 0;
    localparam int TRACE_DUMP_SELECT_BIT = 7;
    // ----------------------------------------------------------------
    // response layout and lengths
    // ----------------------------------------------------------------
    localparam logic [15:0] POS_RESP_LEN = 16'h0014;
    localparam int AT_PARTITION_START_BIT = 7;
    localparam int NEAR_PARTITION_END_BIT = 6;
    localparam int POSITION_UNKNOWN_BIT = 2;
    localparam logic [15:0] TRACE_LEN = 16'h0500;
    localparam logic [15:0] DIAG_HDR_LEN = 16'h0004;
    localparam logic [15:0] SELFTEST_PARAM_LEN = 16'h0001;
    localparam logic [7:0] PAGE_POWER_ON = 8'h90;
    localparam logic [7:0] PAGE_FULL_TEST = 8'h91;
    localparam logic [7:0] PAGE_MEM_DUMP = 8'h94;
    localparam logic [7:0] CODE_PASS = 8'h00;
    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CDB_LO = 4'h0;
    localparam logic [3:0] REG_CDB_HI = 4'h4;
    localparam logic [3:0] REG_CTRL = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    // ----------------------------------------------------------------
    // command sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {TPD_IDLE, TPD_DECODE, TPD_SEND, TPD_FINISH} tpd_state_e;
endpackage

// ===== shared/tpd_stream_if.sv
// byte stream carrier between command sequencer and data-in sender
`timescale 1ns/1ps
interface tpd_stream_if;
    logic start; // one-cycle pulse that launches a transfer
    logic [15:0] count; // bytes to send, smaller of allocation and available for a fetch, fixed length for a position query
    logic [15:0] index; // index of the byte the sender wants next
    logic [7:0] srcByte; // byte at index, looked up by the sequencer
    logic busy; // transfer in progress, high from the start pulse
    modport ctl (output start, output count, output srcByte, input index, input busy);
    modport snd (input start, input count, input srcByte, output index, output busy);
endinterface

// ===== design/tpd_pos_fmt.sv
// byte lookup for the position query response
`timescale 1ns/1ps
module tpd_pos_fmt
(
    input wire logic [15:0] index,
    input wire logic atStart,
    input wire logic nearEnd,
    input wire logic posUnknown,
    input wire logic dualPartition,
    input wire logic inFirstPartition,
    input wire logic [31:0] nextBlockAddr,
    output logic [7:0] respByte
);
    import tpd_pkg::*;
    // ----------------------------------------------------------------
    // byte selection
    // ----------------------------------------------------------------
    // position flags, partition number and block address, big-endian
    always_comb begin
        respByte = 8'h00; // last block and buffer counts stay zero (see R12)
        unique case (index)
            16'h0000: begin
                respByte[AT_PARTITION_START_BIT] = atStart; // (see R6)
                respByte[NEAR_PARTITION_END_BIT] = nearEnd; // (see R7)
                respByte[POSITION_UNKNOWN_BIT] = posUnknown; // (see R8)
            end
            // first partition reads 1, second or unpartitioned reads 0 (see R9)
            16'h0001: respByte = {7'h00, dualPartition & inFirstPartition};
            16'h0004: respByte = nextBlockAddr[31:24]; // (see R10) (see R24)
            16'h0005: respByte = nextBlockAddr[23:16];
            16'h0006: respByte = nextBlockAddr[15:8];
            16'h0007: respByte = nextBlockAddr[7:0];
            default: respByte = 8'h00;
        endcase
    end
endmodule

// ===== design/tpd_byte_sender.sv
// data-in phase sender: streams a fixed count of bytes with back-pressure
`timescale 1ns/1ps
module tpd_byte_sender (
    input wire logic clk,
    input wire logic reset_n,
    tpd_stream_if.snd strm,
    output logic dataInValid,
    output logic [7:0] dataInByte,
    input wire logic dataInReady
);
    import tpd_pkg::*;

    logic activeFf; // transfer running
    logic [15:0] idxFf; // next byte index to fetch
    logic [15:0] countFf; // bytes in this transfer
    logic validFf; // output byte holds data
    logic [7:0] byteFf; // output byte

    logic slotFree; // output register may take a new byte
    logic more; // bytes left to fetch

    assign slotFree = !validFf || dataInReady;
    assign more = activeFf && (idxFf < countFf);
    assign strm.index = idxFf;
    assign strm.busy = strm.start || activeFf;
    assign dataInValid = validFf;
    assign dataInByte = byteFf;

    // ----------------------------------------------------------------
    // transfer bookkeeping
    // ----------------------------------------------------------------
    // phase ends once the cut count has gone out (see R16)
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            activeFf <= 1'b0;
            idxFf <= 16'h0000;
            countFf <= 16'h0000;
        end else if (strm.start) begin
            activeFf <= 1'b1;
            idxFf <= 16'h0000;
            countFf <= strm.count;
        end else if (more && slotFree) begin
            idxFf <= idxFf + 16'h0001;
        end else if (activeFf && !more && !validFf) begin
            activeFf <= 1'b0; // last byte accepted
        end
    end

    // ----------------------------------------------------------------
    // output byte register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            validFf <= 1'b0;
            byteFf <= 8'h00;
        end else if (more && slotFree) begin
            validFf <= 1'b1;
            byteFf <= strm.srcByte;
        end else if (dataInReady) begin
            validFf <= 1'b0; // byte taken, nothing new
        end
    end
endmodule

// ===== tb/tpd_sink.sv
// data-in sink standing in for the initiator's host adapter
`timescale 1ns/1ps
module tpd_sink (
    input wire logic clk,
    input wire logic clr,
    input wire logic slow,
    input wire logic dataInValid,
    input wire logic [7:0] dataInByte,
    output logic dataInReady
);
    logic [7:0] got[$]; // bytes accepted since the last clear
    logic ph = 1'b0; // stall phase, toggles every cycle
    // collect each byte that moves on valid and ready
    always @(posedge clk) begin
        ph <= ~ph;
        if (clr) got.delete();
        else if (dataInValid && dataInReady) got.push_back(dataInByte);
    end
    // slow mode stalls every other cycle
    assign dataInReady = ~slow | ph;
endmodule

// ===== tb/tpd_cmd_top_tb.sv
// self-checking bench for the position and diagnostic command block
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tpd_cmd_top_tb;
    import tpd_pkg::*;
    logic clk = 0, reset_n = 0, read = 0, write = 0, clr = 0, slow = 1, stDone = 0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, nba = 32'h12345678, st;
    logic waitrequest, dataInValid, dataInReady, memTraceSel;
    logic [7:0] dataInByte, memData, stPage = 8'h0, stCode = 8'h0;
    logic [15:0] memAddr, dl = 16'h0002; // dump page length fed to the block
    logic [6:0] drv = 7'b1011011; // cartridge legacy known start end dual first
    int n_mismatch = 0, cmp_count = 0;
    always #5 clk = ~clk;
    // trace memory model: byte follows its index, top bit marks the trace
    assign memData = memAddr[7:0] ^ {memTraceSel, 7'h0};
    tpd_cmd_top tpd_cmd_top_i (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .cartridgePresent(drv[6]), .legacyFormat(drv[5]), .positionKnown(drv[4]),
        .atPartitionStart(drv[3]), .nearPartitionEnd(drv[2]), .dualPartition(drv[1]),
        .inFirstPartition(drv[0]), .nextBlockAddr(nba), .selfTestDone(stDone),
        .selfTestPage(stPage), .selfTestCode(stCode), .dumpLength(dl),
        .memAddr(memAddr), .memTraceSel(memTraceSel), .memData(memData),
        .dataInValid(dataInValid), .dataInByte(dataInByte), .dataInReady(dataInReady));
    tpd_sink tpd_sink_i (.clk(clk), .clr(clr), .slow(slow), .dataInValid(dataInValid),
        .dataInByte(dataInByte), .dataInReady(dataInReady));
    // expected status word with done set
    function automatic logic [31:0] stw(logic [3:0] k, logic [7:0] s, logic [7:0] a);
        return {ASCQ_NONE, a, s, 2'b00, k, 2'b01};
    endfunction
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        n = 0;
        // sample at each rising edge until the slave stops stalling
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest && n < 50);
        st = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest) n_mismatch++;
    endtask
    // load the command block, launch, poll for done, check status and byte count
    task automatic cmd(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] es,
        input int nb);
        int n;
        clr <= 1'b1;
        bus(1'b1, REG_CDB_LO, lo);
        clr <= 1'b0;
        bus(1'b1, REG_CDB_HI, hi);
        bus(1'b1, REG_CTRL, 32'h1);
        n = 0;
        st = 32'h0;
        while (!st[0] && n < 3000) begin
            bus(1'b0, REG_STATUS, 32'h0);
            n++;
        end
        `CHK(st, es)
        `CHK(tpd_sink_i.got.size(), nb)
        $display("test done, compares %0d", cmp_count);
    endtask
    // position query with the whole 20-byte answer compared
    task automatic posq(input logic [159:0] e);
        cmd({24'h0, OP_POS_QUERY}, 32'h0, stw(SK_NONE, ST_GOOD, ASC_NONE), 20);
        for (int i = 0; i < 20; i++) `CHK(tpd_sink_i.got[i], e[159 - 8 * i -: 8])
    endtask
    // diagnostic fetch; trace bytes follow the memory model, page bytes come from pg
    task automatic fetch(input logic dumpSel, input logic [15:0] al, input int nb,
        input logic [39:0] pg);
        cmd({al[15:8], 16'h0, OP_DIAG_FETCH}, {16'h0, dumpSel, 7'h0, al[7:0]},
            stw(SK_NONE, ST_GOOD, ASC_NONE), nb);
        for (int i = 0; i < nb; i++) `CHK(tpd_sink_i.got[i], dumpSel ? (i[7:0] ^ 8'h80) : pg[39 - 8 * i -: 8])
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        posq({8'h80, 8'h01, 16'h0, 32'h12345678, 96'h0});
        drv <= 7'b1000101;
        nba <= 32'hfedcba98;
        posq({8'h44, 8'h00, 16'h0, 32'hfedcba98, 96'h0});
        drv <= 7'b0011011;
        cmd({24'h0, OP_POS_QUERY}, 32'h0, stw(SK_NOT_READY, ST_CHECK, ASC_NO_MEDIUM), 0);
        drv <= 7'b1111011;
        cmd({24'h0, OP_POS_QUERY}, 32'h0, stw(SK_ILLEGAL, ST_CHECK, ASC_INCOMPAT), 0);
        drv <= 7'b1011011;
        cmd(32'h0000_0134, 32'h0, stw(SK_ILLEGAL, ST_CHECK, ASC_BAD_FIELD), 0);
        cmd(32'h0000_0012, 32'h0, stw(SK_ILLEGAL, ST_CHECK, ASC_BAD_OPCODE), 0);
        fetch(1'b1, TRACE_LEN, 1280, 40'h0);
        fetch(1'b1, 16'h0003, 3, 40'h0);
        for (int k = 0; k < 2; k++) begin
            stPage <= k ? PAGE_FULL_TEST : PAGE_POWER_ON;
            stCode <= k ? 8'h07 : CODE_PASS;
            stDone <= 1'b1;
            @(posedge clk);
            stDone <= 1'b0;
            fetch(1'b0, 16'h0005, 5, {stPage, 8'h00, 16'h0001, stCode});
            fetch(1'b0, 16'h0002, 2, {stPage, 8'h00, 24'h0});
        end
        stPage <= PAGE_MEM_DUMP;
        stDone <= 1'b1;
        @(posedge clk);
        stDone <= 1'b0;
        fetch(1'b0, 16'h0005, 5, {PAGE_MEM_DUMP, 24'h000002, 8'h00});
        fetch(1'b0, 16'h0000, 0, 40'h0);
        tally_and_finish();
    end
    // watchdog well beyond the expected run length
    initial begin
        #500000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
